// File: hw/ocs_stage.sv
// One overcurrent stage: blocking, start, trip and release sequencing
`timescale 1ns/1ps
module ocs_stage (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  ocs_stage_if.stg bus
);
  import ocs_pkg::*;
  ocs_state_t state, next_state;
  logic [DLY_W-1:0] trip_cnt, next_trip_cnt, rel_cnt, next_rel_cnt;
  logic start, trip, blocked, next_start, next_trip, next_blocked;
  logic blk_s, inr, trip_due, rel_due;

  always_comb begin
    blk_s = bus.blk_ext | (bus.force_en & bus.force_blk);
    inr = bus.inrush_en & (bus.harm > bus.harm_lim);
    trip_due = bus.idmt ? bus.idmt_trip : (trip_cnt >= bus.trip_dly);
    rel_due = bus.idmt ? bus.idmt_reset : (rel_cnt >= bus.rst_dly);
    next_state = state;
    next_trip_cnt = trip_cnt;
    next_rel_cnt = rel_cnt;
    if (bus.tick) begin
      unique case (state)
        ST_IDLE: begin
          if (bus.pickup) begin
            next_state = blk_s ? ST_BLOCKED : ST_START;
          end
        end
        ST_START: begin
          if (blk_s || !bus.pickup) begin
            next_state = ST_RELEASE;
            next_rel_cnt = '0;
          end else if (!inr && trip_due) begin
            next_state = ST_TRIP;
          end else if (!inr) begin
            next_trip_cnt = trip_cnt + 1'b1;
          end
        end
        ST_TRIP: begin
          if (blk_s || !bus.pickup) begin
            next_state = ST_RELEASE;
            next_rel_cnt = '0;
          end
        end
        ST_BLOCKED: begin
          if (!bus.pickup) begin
            next_state = ST_IDLE;
          end
        end
        ST_RELEASE: begin
          if (bus.pickup && !blk_s) begin
            next_state = ST_START;
          end else if (rel_due) begin
            next_state = ST_IDLE;
            next_trip_cnt = '0;
          end else begin
            next_rel_cnt = rel_cnt + 1'b1;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
    next_start = (next_state == ST_START) || (next_state == ST_TRIP);
    next_trip = next_state == ST_TRIP;
    next_blocked = next_state == ST_BLOCKED;
    if (bus.force_en && bus.force_sts != FRC_NORMAL) begin
      next_start = bus.force_sts != FRC_BLOCKED;
      next_trip = bus.force_sts == FRC_TRIP;
      next_blocked = bus.force_sts == FRC_BLOCKED;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      trip_cnt <= '0;
      rel_cnt <= '0;
      start <= 1'b0;
      trip <= 1'b0;
      blocked <= 1'b0;
    end else begin
      state <= next_state;
      trip_cnt <= next_trip_cnt;
      rel_cnt <= next_rel_cnt;
      start <= next_start;
      trip <= next_trip;
      blocked <= next_blocked;
    end
  end

  assign bus.start = start;
  assign bus.trip = trip;
  assign bus.blocked = blocked;
  assign bus.inrush = inr;
  assign bus.state = state;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  chk_start_unblocked: assert property (
    bus.tick && state == ST_IDLE && bus.pickup && !blk_s |=> state == ST_START)
    else $error("pick-up without block did not start");
  chk_block_at_pickup: assert property (
    bus.tick && state == ST_IDLE && bus.pickup && blk_s |=> state == ST_BLOCKED ##1 !start)
    else $error("blocked pick-up did not give blocked");
  chk_block_drops_start: assert property (
    bus.tick && state == ST_START && blk_s |=> state == ST_RELEASE)
    else $error("late block did not release start");
  chk_inrush_holds: assert property (
    bus.tick && state == ST_START && inr && !blk_s && bus.pickup |=> state == ST_START)
    else $error("inrush did not hold the trip");
  chk_dt_trip: assert property (
    bus.tick && state == ST_START && !bus.idmt && !inr && !blk_s && bus.pickup
    && trip_cnt >= bus.trip_dly |=> state == ST_TRIP)
    else $error("definite time expiry did not trip");
  chk_force_trip: assert property (
    bus.force_en && bus.force_sts == FRC_TRIP |=> trip && start && !blocked)
    else $error("forced trip not shown");
endmodule : ocs_stage

// File: hw/ocs_top.sv
// Four overcurrent stages with event emission and fault records
//
// What this block does
// - Blocking input registered twice on every clock, read by the stages at each program cycle tick
// - Pick-up without block asserts start and begins trip timing
// - Inrush blocking option, default off, holds only the trip
// - Inrush blocks when harmonic ratio exceeds limit in 0.01 percent steps
// - Block present at pick-up gives blocked output and nothing further
// - Block after start drops start and runs the release timing
// - Each blocked output ON raises a display flag and a stamped block event
// - Software block switch works while stage forcing is enabled
// - Trip and release delay selectable as definite or inverse time
// - Every start, trip or blocked change gives an event, each ON change a record update
// - Setting selects ON events, OFF events or both for the buffer
// - Four independent stages, each with its own identified events
// - Each event carries a time stamp and process values
// - Paired events for no voltage, live angle and angle memory
// - Each stage keeps its twelve most recent records
// - Records written only for start, trip or blocked ON events
// - Record holds stamp, event, fault type, currents, time left, group, angle
// - Forcing sets stage output: normal, start, trip or blocked
`timescale 1ns/1ps
module ocs_top #(
  parameter int P_CYCLE_CYC = ocs_pkg::PROG_CYCLE_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [9:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [ocs_pkg::N_STAGE-1:0] i_pickup,
  input wire logic [ocs_pkg::N_STAGE-1:0] i_block_pin,
  input wire logic [ocs_pkg::N_STAGE-1:0] i_idmt_trip,
  input wire logic [ocs_pkg::N_STAGE-1:0] i_idmt_reset,
  input wire logic [ocs_pkg::N_STAGE-1:0] i_no_voltage,
  input wire logic [ocs_pkg::N_STAGE-1:0] i_live_angle,
  input wire logic [ocs_pkg::N_STAGE-1:0] i_volt_mem,
  input wire logic [ocs_pkg::N_STAGE-1:0][15:0] i_harmonic_to_fundamental_ratio,
  input wire logic [ocs_pkg::N_STAGE-1:0][15:0] i_fault_cur,
  input wire logic [ocs_pkg::N_STAGE-1:0][15:0] i_pre_cur,
  input wire logic [ocs_pkg::N_STAGE-1:0][15:0] i_avg_cur,
  input wire logic [ocs_pkg::N_STAGE-1:0][15:0] i_time_left,
  input wire logic [ocs_pkg::N_STAGE-1:0][15:0] i_angle,
  input wire logic [ocs_pkg::N_STAGE-1:0][3:0] i_fault_type,
  input wire logic [2:0] i_setting_group_in_use,
  output logic [ocs_pkg::N_STAGE-1:0] o_start,
  output logic [ocs_pkg::N_STAGE-1:0] o_trip,
  output logic [ocs_pkg::N_STAGE-1:0] o_blocked,
  output logic [ocs_pkg::N_STAGE-1:0] o_hmi_block,
  output logic o_evt_valid,
  output logic [1:0] o_evt_stage,
  output ocs_pkg::ocs_evt_t o_evt_code,
  output logic [31:0] o_evt_stamp,
  output logic [15:0] o_evt_cur,
  output logic [3:0] o_evt_ftype
);
  import ocs_pkg::*;

  function automatic logic [6:0] ocs_first(input logic [63:0] v);
    logic [6:0] r;
    r = '0;
    for (int i = 63; i >= 0; i--) begin
      if (v[i]) r = {1'b1, 6'(i)};
    end
    return r;
  endfunction : ocs_first

  function automatic logic [31:0] ocs_field(input ocs_rec_t r, input logic [2:0] f);
    unique case (f)
      3'h0: return r.stamp;
      3'h1: return {21'h0, r.grp, r.ftype, r.evt};
      3'h2: return {16'h0, r.pre_cur};
      3'h3: return {16'h0, r.flt_cur};
      3'h4: return {16'h0, r.avg_cur};
      3'h5: return {16'h0, r.left};
      3'h6: return {16'h0, r.angle};
      default: return 32'h0;
    endcase
  endfunction : ocs_field

  ////////////////////////////////////////////////////////////////////////////
  // Program cycle divider and millisecond time base
  logic [31:0] tcnt, next_tcnt, stamp, next_stamp;
  logic tick, next_tick;
  logic [N_STAGE-1:0] blk_m, blk_s;

  always_comb begin
    next_tick = tcnt == 32'(P_CYCLE_CYC - 1);
    next_tcnt = next_tick ? 32'h0 : tcnt + 32'h1;
    next_stamp = tick ? stamp + 32'h1 : stamp;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      tcnt <= 32'h0;
      tick <= 1'b0;
      stamp <= 32'h0;
      blk_m <= '0;
      blk_s <= '0;
    end else begin
      tcnt <= next_tcnt;
      tick <= next_tick;
      stamp <= next_stamp;
      blk_m <= i_block_pin;
      blk_s <= blk_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic force_en, next_force_en;
  ocs_evsel_t evsel, next_evsel;
  logic [N_STAGE-1:0][4:0] cfg, next_cfg;
  logic [N_STAGE-1:0][15:0] hlim, next_hlim, tdly, next_tdly, rdly, next_rdly;
  logic [31:0] next_rdata;
  logic [N_STAGE-1:0][3:0] wptr, next_wptr, cnt, next_cnt;
  ocs_rec_t rec [N_STAGE][REC_DEPTH];
  ocs_rec_t next_rec [N_STAGE][REC_DEPTH];
  ocs_stage_if sif [N_STAGE] ();
  logic [N_STAGE-1:0][5:0] stat_st;
  logic [1:0] as;

  always_comb begin
    as = i_addr[1:0];
    next_force_en = force_en;
    next_evsel = evsel;
    next_cfg = cfg;
    next_hlim = hlim;
    next_tdly = tdly;
    next_rdly = rdly;
    if (i_wr) begin
      if (i_addr == A_CTRL) begin
        next_force_en = i_wdata[CTRL_FORCE_BIT];
        next_evsel = ocs_evsel_t'(i_wdata[CTRL_SEL_LSB +: 2]);
      end
      if (i_addr[9:2] == A_CFG[9:2]) next_cfg[as] = i_wdata[4:0];
      if (i_addr[9:2] == A_HLIM[9:2]) next_hlim[as] = i_wdata[15:0];
      if (i_addr[9:2] == A_TDLY[9:2]) next_tdly[as] = i_wdata[15:0];
      if (i_addr[9:2] == A_RDLY[9:2]) next_rdly[as] = i_wdata[15:0];
    end
    next_rdata = 32'h0;
    if (i_rd) begin
      if (i_addr[REC_SEL_BIT]) begin
        if (i_addr[6:3] < 4'(REC_DEPTH)) begin
          next_rdata = ocs_field(rec[i_addr[8:7]][i_addr[6:3]], i_addr[2:0]);
        end
      end else if (i_addr == A_CTRL) begin
        next_rdata = {29'h0, evsel, force_en};
      end else if (i_addr == A_TIME) begin
        next_rdata = stamp;
      end else if (i_addr[9:2] == A_CFG[9:2]) begin
        next_rdata = {27'h0, cfg[as]};
      end else if (i_addr[9:2] == A_HLIM[9:2]) begin
        next_rdata = {16'h0, hlim[as]};
      end else if (i_addr[9:2] == A_TDLY[9:2]) begin
        next_rdata = {16'h0, tdly[as]};
      end else if (i_addr[9:2] == A_RDLY[9:2]) begin
        next_rdata = {16'h0, rdly[as]};
      end else if (i_addr[9:2] == A_STAT[9:2]) begin
        next_rdata = {16'h0, cnt[as], wptr[as], 2'h0, stat_st[as]};
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      force_en <= CTRL_RST[CTRL_FORCE_BIT];
      evsel <= ocs_evsel_t'(CTRL_RST[CTRL_SEL_LSB +: 2]);
      cfg <= {N_STAGE{CFG_RST}};
      hlim <= {N_STAGE{HLIM_RST}};
      tdly <= {N_STAGE{TDLY_RST}};
      rdly <= {N_STAGE{RDLY_RST}};
      o_rdata <= 32'h0;
    end else begin
      force_en <= next_force_en;
      evsel <= next_evsel;
      cfg <= next_cfg;
      hlim <= next_hlim;
      tdly <= next_tdly;
      rdly <= next_rdly;
      o_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage instances
  logic [N_STAGE-1:0][5:0] cur_sig, prev_sig;

  for (genvar g = 0; g < N_STAGE; g++) begin : g_stage
    assign sif[g].tick = tick;
    assign sif[g].pickup = i_pickup[g];
    assign sif[g].blk_ext = blk_s[g];
    assign sif[g].inrush_en = cfg[g][CFG_INRUSH_BIT];
    assign sif[g].idmt = cfg[g][CFG_IDMT_BIT];
    assign sif[g].force_en = force_en;
    assign sif[g].force_blk = cfg[g][CFG_FBLK_BIT];
    assign sif[g].force_sts = ocs_force_t'(cfg[g][CFG_FSTS_LSB +: 2]);
    assign sif[g].idmt_trip = i_idmt_trip[g];
    assign sif[g].idmt_reset = i_idmt_reset[g];
    assign sif[g].harm = i_harmonic_to_fundamental_ratio[g];
    assign sif[g].harm_lim = hlim[g];
    assign sif[g].trip_dly = tdly[g];
    assign sif[g].rst_dly = rdly[g];
    assign o_start[g] = sif[g].start;
    assign o_trip[g] = sif[g].trip;
    assign o_blocked[g] = sif[g].blocked;
    assign stat_st[g] = {sif[g].inrush, sif[g].state};
    assign cur_sig[g] = {i_volt_mem[g], i_live_angle[g], i_no_voltage[g],
      sif[g].blocked, sif[g].trip, sif[g].start};
    ocs_stage ocs_stage_inst (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .bus(sif[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event queue, event output and fault records
  logic [63:0] pend, next_pend, set, clr;
  logic [6:0] pick;
  logic fnd, on_rec;
  logic [1:0] ps;
  logic [3:0] pc;
  logic next_evt_valid;
  logic [N_STAGE-1:0] next_hmi;

  always_comb begin
    set = '0;
    for (int s = 0; s < N_STAGE; s++) begin
      for (int k = 0; k < 6; k++) begin
        set[s*16 + 2*k] = cur_sig[s][k] & ~prev_sig[s][k];
        set[s*16 + 2*k + 1] = ~cur_sig[s][k] & prev_sig[s][k];
      end
    end
    pick = ocs_first(pend);
    fnd = pick[6];
    ps = pick[5:4];
    pc = pick[3:0];
    clr = '0;
    clr[pick[5:0]] = fnd;
    next_pend = (pend & ~clr) | set;
    on_rec = fnd && !pc[0] && (pc[3:1] < 3'h3);
    next_evt_valid = fnd && (pc[0] ? evsel[1] : evsel[0]);
    next_hmi = '0;
    next_hmi[ps] = fnd && (pc == EV_BLK_ON);
    next_wptr = wptr;
    next_cnt = cnt;
    next_rec = rec;
    if (on_rec) begin
      next_rec[ps][wptr[ps]] = '{stamp: stamp, grp: i_setting_group_in_use,
        ftype: i_fault_type[ps], evt: pc, pre_cur: i_pre_cur[ps],
        flt_cur: i_fault_cur[ps], avg_cur: i_avg_cur[ps], left: i_time_left[ps],
        angle: i_angle[ps]};
      next_wptr[ps] = (wptr[ps] == 4'(REC_DEPTH - 1)) ? 4'h0 : wptr[ps] + 4'h1;
      if (cnt[ps] != 4'(REC_DEPTH)) next_cnt[ps] = cnt[ps] + 4'h1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pend <= '0;
      prev_sig <= '0;
      wptr <= '0;
      cnt <= '0;
      for (int s = 0; s < N_STAGE; s++) begin
        for (int e = 0; e < REC_DEPTH; e++) rec[s][e] <= '0;
      end
      o_evt_valid <= 1'b0;
      o_evt_stage <= 2'h0;
      o_evt_code <= EV_START_ON;
      o_evt_stamp <= 32'h0;
      o_evt_cur <= 16'h0;
      o_evt_ftype <= 4'h0;
      o_hmi_block <= '0;
    end else begin
      pend <= next_pend;
      prev_sig <= cur_sig;
      wptr <= next_wptr;
      cnt <= next_cnt;
      rec <= next_rec;
      o_evt_valid <= next_evt_valid;
      o_evt_stage <= ps;
      o_evt_code <= ocs_evt_t'(pc);
      o_evt_stamp <= stamp;
      o_evt_cur <= i_fault_cur[ps];
      o_evt_ftype <= i_fault_type[ps];
      o_hmi_block <= next_hmi;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  chk_tick_period: assert property (tick |-> tcnt == 32'h0 ##1 !tick && tcnt == 32'h1)
    else $error("program cycle tick malformed");
  chk_pend_set_wins: assert property (set[20] |=> pend[20])
    else $error("block event lost");
  chk_rec_on_only: assert property ($changed(wptr[0]) |-> $past(on_rec && ps == 2'h0))
    else $error("record written without an ON event");
  chk_rec_wrap: assert property (
    on_rec && ps == 2'h2 && wptr[2] == 4'hB |=> wptr[2] == 4'h0 && cnt[2] == 4'hC)
    else $error("record did not wrap");
  chk_evt_filter: assert property (
    o_evt_valid |-> (o_evt_code[0] ? $past(evsel[1]) : $past(evsel[0])))
    else $error("event passed the filter wrongly");
  chk_hmi_block: assert property (fnd && pick[5:0] == 6'h14 |=> o_hmi_block[1])
    else $error("block without display flag");
  chk_evt_stamp: assert property (o_evt_valid |-> o_evt_stamp == $past(stamp))
    else $error("event stamp wrong");
  cov_trip_evt: cover property (o_evt_valid && o_evt_code == EV_TRIP_ON);
  cov_rec_wrap: cover property (on_rec && wptr[2] == 4'hB);
  cov_hmi: cover property (o_hmi_block[1]);
endmodule : ocs_top

// File: pkg/ocs_pkg.sv
// Shared constants and types of the overcurrent stage block
package ocs_pkg;
  localparam int N_STAGE = 4;
  localparam int REC_DEPTH = 12;
  localparam int DLY_W = 16;
  localparam int CUR_W = 16;
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_CYCLE_US = 1000;
  localparam int PROG_CYCLE_CYC = PROG_CYCLE_US * 1000 / CLK_PERIOD_NS;
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [9:0] A_CTRL = 10'h000;
  localparam logic [9:0] A_TIME = 10'h001;
  localparam logic [9:0] A_CFG = 10'h010;
  localparam logic [9:0] A_HLIM = 10'h014;
  localparam logic [9:0] A_TDLY = 10'h018;
  localparam logic [9:0] A_RDLY = 10'h01C;
  localparam logic [9:0] A_STAT = 10'h020;
  localparam int REC_SEL_BIT = 9;
  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam int CFG_INRUSH_BIT = 0;
  localparam int CFG_IDMT_BIT = 1;
  localparam int CFG_FBLK_BIT = 2;
  localparam int CFG_FSTS_LSB = 3;
  localparam logic [2:0] CTRL_RST = 3'h6;
  localparam logic [4:0] CFG_RST = 5'h00;
  localparam logic [15:0] HLIM_RST = 16'h0001;
  localparam logic [15:0] TDLY_RST = 16'h0064;
  localparam logic [15:0] RDLY_RST = 16'h0000;
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    EVS_NONE = 2'h0, EVS_ON = 2'h1, EVS_OFF = 2'h2, EVS_BOTH = 2'h3
  } ocs_evsel_t;
  typedef enum logic [1:0] {
    FRC_NORMAL = 2'h0, FRC_START = 2'h1, FRC_TRIP = 2'h2, FRC_BLOCKED = 2'h3
  } ocs_force_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_START = 5'h02, ST_TRIP = 5'h04, ST_BLOCKED = 5'h08,
    ST_RELEASE = 5'h10
  } ocs_state_t;
  typedef enum logic [3:0] {
    EV_START_ON = 4'h0, EV_START_OFF = 4'h1, EV_TRIP_ON = 4'h2, EV_TRIP_OFF = 4'h3,
    EV_BLK_ON = 4'h4, EV_BLK_OFF = 4'h5, EV_NOVOLT_ON = 4'h6, EV_NOVOLT_OFF = 4'h7,
    EV_LIVE_ON = 4'h8, EV_LIVE_OFF = 4'h9, EV_MEM_ON = 4'hA, EV_MEM_OFF = 4'hB
  } ocs_evt_t;
  typedef struct packed {
    logic [31:0] stamp;
    logic [2:0] grp;
    logic [3:0] ftype;
    logic [3:0] evt;
    logic [15:0] pre_cur;
    logic [15:0] flt_cur;
    logic [15:0] avg_cur;
    logic [15:0] left;
    logic [15:0] angle;
  } ocs_rec_t;
endpackage : ocs_pkg

// File: pkg/ocs_stage_if.sv
// Signals between the top and one stage
`timescale 1ns/1ps
interface ocs_stage_if;
  logic tick, pickup, blk_ext, inrush_en, idmt, force_en, force_blk;
  logic idmt_trip, idmt_reset;
  logic [15:0] harm, harm_lim, trip_dly, rst_dly;
  ocs_pkg::ocs_force_t force_sts;
  logic start, trip, blocked, inrush;
  ocs_pkg::ocs_state_t state;
  modport ctl(output tick, pickup, blk_ext, inrush_en, idmt, force_en, force_blk,
    idmt_trip, idmt_reset, harm, harm_lim, trip_dly, rst_dly, force_sts,
    input start, trip, blocked, inrush, state);
  modport stg(input tick, pickup, blk_ext, inrush_en, idmt, force_en, force_blk,
    idmt_trip, idmt_reset, harm, harm_lim, trip_dly, rst_dly, force_sts,
    output start, trip, blocked, inrush, state);
endinterface : ocs_stage_if

// File: tb/ocs_partner.sv
// Blocking matrix and event buffer around the stage block
`timescale 1ns/1ps
module ocs_partner (
  input wire logic i_clk_sys,
  input wire logic [3:0] i_blk_cmd,
  output logic [3:0] o_block_pin,
  input wire logic i_evt_valid,
  input wire logic [1:0] i_evt_stage,
  input wire logic [3:0] i_evt_code,
  input wire logic [3:0] i_hmi,
  output logic [5:0] o_last,
  output int o_off_cnt,
  output int o_hmi_cnt
);
  import ocs_pkg::*;
  initial begin
    o_block_pin = 4'h0;
    o_last = 6'h00;
    o_off_cnt = 0;
    o_hmi_cnt = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Matrix output is a register, raised long before any delay runs out
  always @(posedge i_clk_sys) begin
    o_block_pin <= i_blk_cmd;
    if (i_evt_valid === 1'b1) begin
      o_last <= {i_evt_stage, i_evt_code};
      o_off_cnt <= o_off_cnt + int'(i_evt_code[0]);
    end
    o_hmi_cnt <= o_hmi_cnt + int'(i_hmi != 4'h0);
  end
endmodule : ocs_partner

// File: tb/ocs_top_tb.sv
// Self-checking bench of the four-stage overcurrent block
`timescale 1ns/1ps
module ocs_top_tb;
  import ocs_pkg::*;
  localparam int PC = 8;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ev_v;
  logic [9:0] addr = 10'h000;
  logic [31:0] wdata = 32'h0, rdata, rv, ev_st;
  logic [3:0] pick = 4'h0, blk_cmd = 4'h0, blk_pin, hmi, start, trip, blocked, ev_c, ev_ft;
  logic [2:0][3:0] aux = '0;
  logic [3:0] idt = 4'h0, idr = 4'h0;
  logic [3:0][15:0] harm = '0, fc, pcur, ac, tl, ang;
  logic [3:0][3:0] ft;
  logic [2:0] grp;
  logic [1:0] ev_s;
  logic [15:0] ev_cur, lim;
  logic [5:0] last;
  int num_errors = 0, checked = 0, off_cnt, hmi_cnt, k, n;
  always #50 clk = ~clk;
  ocs_top #(.P_CYCLE_CYC(PC)) ocs_top_inst (.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pickup(pick),
    .i_block_pin(blk_pin), .i_idmt_trip(idt), .i_idmt_reset(idr), .i_no_voltage(aux[0]),
    .i_live_angle(aux[1]), .i_volt_mem(aux[2]), .i_harmonic_to_fundamental_ratio(harm),
    .i_fault_cur(fc), .i_pre_cur(pcur), .i_avg_cur(ac), .i_time_left(tl), .i_angle(ang),
    .i_fault_type(ft), .i_setting_group_in_use(grp), .o_start(start), .o_trip(trip),
    .o_blocked(blocked), .o_hmi_block(hmi), .o_evt_valid(ev_v), .o_evt_stage(ev_s),
    .o_evt_code(ev_c), .o_evt_stamp(ev_st), .o_evt_cur(ev_cur), .o_evt_ftype(ev_ft));
  ocs_partner ocs_partner_inst (.i_clk_sys(clk), .i_blk_cmd(blk_cmd), .o_block_pin(blk_pin),
    .i_evt_valid(ev_v), .i_evt_stage(ev_s), .i_evt_code(ev_c), .i_hmi(hmi), .o_last(last),
    .o_off_cnt(off_cnt), .o_hmi_cnt(hmi_cnt));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr_reg(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [9:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask : rd_reg
  // Waits for start (0), trip (1) or blocked (2) of stage i to reach v
  task wait_out(input int w, input int i, input logic v);
    for (n = 0; n < 400; n++) begin
      if (((w == 0) ? start[i] : (w == 1) ? trip[i] : blocked[i]) === v) break;
      @(posedge clk);
    end
  endtask : wait_out
  task ev_chk(input logic [1:0] s, input logic [3:0] c);
    repeat (4) @(posedge clk);
    chk(last, {s, c});
  endtask : ev_chk
  function automatic logic [9:0] rec(input int s, input int slot, input int f);
    return {1'b1, 2'(s), 4'(slot), 3'(f)};
  endfunction : rec
  function automatic logic [2:0] forced(input int code);
    return (code == 3) ? 3'h4 : (code == 2) ? 3'h3 : 3'h1;
  endfunction : forced
  task results();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    results();
  end
  initial begin
    k = $urandom(32'hEC0B8423);
    fc = {$urandom, $urandom};
    pcur = {$urandom, $urandom};
    ac = {$urandom, $urandom};
    tl = {$urandom, $urandom};
    ang = {$urandom, $urandom};
    ft = 16'($urandom);
    grp = 3'($urandom);
    lim = 16'(100 + $urandom % 4000);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(A_CTRL);
    chk(rv, 32'h6);
    rd_reg(A_CFG);
    chk(rv, 32'h0);
    rd_reg(A_HLIM);
    chk(rv, 32'h1);
    rd_reg(A_STAT + 10'h3);
    chk(rv, 32'h1);
    rd_reg(10'h0FF);
    chk(rv, 32'h0);
    $display("test reset done");
    wr_reg(A_TDLY, 32'h3);
    pick[0] <= 1'b1;
    wait_out(0, 0, 1'b1);
    ev_chk(2'h0, EV_START_ON);
    k = $time / 100;
    wait_out(1, 0, 1'b1);
    k = $time / 100 - k;
    chk(k >= 2 * PC && k <= 4 * PC + 1, 1'b1);
    ev_chk(2'h0, EV_TRIP_ON);
    rd_reg(rec(0, 0, 1));
    chk(rv[10:0], {grp, ft[0], 4'h0});
    rd_reg(rec(0, 1, 3));
    chk(rv, {16'h0, fc[0]});
    $display("test start and trip done");
    blk_cmd[0] <= 1'b1;
    wait_out(0, 0, 1'b0);
    chk({trip[0], start[0]}, 2'h0);
    pick[0] <= 1'b0;
    blk_cmd[0] <= 1'b0;
    repeat (3 * PC) @(posedge clk);
    rd_reg(A_STAT);
    chk(rv[4:0], ST_IDLE);
    $display("test block after start done");
    k = hmi_cnt;
    blk_cmd[1] <= 1'b1;
    repeat (2 * PC) @(posedge clk);
    pick[1] <= 1'b1;
    wait_out(2, 1, 1'b1);
    chk(start[1], 1'b0);
    ev_chk(2'h1, EV_BLK_ON);
    chk(hmi_cnt, k + 1);
    pick[1] <= 1'b0;
    blk_cmd[1] <= 1'b0;
    wait_out(2, 1, 1'b0);
    chk(blocked[1], 1'b0);
    $display("test block at pick-up done");
    wr_reg(A_CTRL, 32'h2);
    // Let the block OFF event of the previous test reach the counter first
    repeat (4) @(posedge clk);
    k = off_cnt;
    pick[2] <= 1'b1;
    wait_out(0, 2, 1'b1);
    pick[2] <= 1'b0;
    wait_out(0, 2, 1'b0);
    repeat (4) @(posedge clk);
    chk(off_cnt, k);
    wr_reg(A_CTRL, 32'h6);
    for (int i = 0; i < 13; i++) begin
      pick[2] <= 1'b1;
      wait_out(0, 2, 1'b1);
      pick[2] <= 1'b0;
      wait_out(0, 2, 1'b0);
    end
    rd_reg(A_STAT + 10'h2);
    chk(rv[15:8], 8'hC2);
    $display("test record wrap done");
    for (int i = 0; i < 3; i++) begin
      aux[i][3] <= 1'b1;
      ev_chk(2'h3, 4'(6 + 2 * i));
      aux[i][3] <= 1'b0;
      ev_chk(2'h3, 4'(7 + 2 * i));
    end
    wr_reg(A_CTRL, 32'h7);
    for (int i = 1; i < 4; i++) begin
      wr_reg(A_CFG + 10'h3, 32'(i << 3));
      repeat (3) @(posedge clk);
      chk({blocked[3], trip[3], start[3]}, forced(i));
    end
    wr_reg(A_CFG + 10'h3, 32'h4);
    // Forced blocked must clear before the software block is judged
    repeat (2) @(posedge clk);
    pick[3] <= 1'b1;
    wait_out(2, 3, 1'b1);
    chk({blocked[3], start[3]}, 2'h2);
    pick[3] <= 1'b0;
    wr_reg(A_CFG + 10'h3, 32'h0);
    wr_reg(A_CTRL, 32'h6);
    $display("test forcing done");
    wr_reg(A_CFG, 32'h1);
    wr_reg(A_HLIM, {16'h0, lim});
    wr_reg(A_TDLY, 32'h2);
    harm[0] <= lim + 16'h1;
    pick[0] <= 1'b1;
    wait_out(0, 0, 1'b1);
    repeat (6 * PC) @(posedge clk);
    chk({trip[0], start[0]}, 2'h1);
    rd_reg(A_STAT);
    chk(rv[5], 1'b1);
    harm[0] <= lim;
    wait_out(1, 0, 1'b1);
    chk(trip[0], 1'b1);
    pick[0] <= 1'b0;
    $display("test inrush done");
    wr_reg(A_CFG + 10'h1, 32'h2);
    wr_reg(A_TDLY + 10'h1, 32'h0);
    pick[1] <= 1'b1;
    wait_out(0, 1, 1'b1);
    repeat (3 * PC) @(posedge clk);
    chk(trip[1], 1'b0);
    idt[1] <= 1'b1;
    wait_out(1, 1, 1'b1);
    chk(trip[1], 1'b1);
    pick[1] <= 1'b0;
    repeat (3 * PC) @(posedge clk);
    rd_reg(A_STAT + 10'h1);
    chk(rv[4:0], ST_RELEASE);
    idr[1] <= 1'b1;
    repeat (2 * PC) @(posedge clk);
    rd_reg(A_STAT + 10'h1);
    chk(rv[4:0], ST_IDLE);
    $display("test inverse time done");
    results();
  end
endmodule : ocs_top_tb
